// ---- verilog/rcs_startup.sv ----
// Reset and clock start-up sequencer, top level
module rcs_startup #(
   parameter int unsigned               LOCK_CYCLES  = rcs_pkg::LOCK_CYCLES,
   parameter logic [rcs_pkg::ADDR_W-1:0] RESET_VECTOR = rcs_pkg::RESET_VECTOR
) (
   // Clock and reset
   input  wire logic                       CLOCK,
   input  wire logic                       RSTN,
   // Configuration pins
   input  wire logic [1:0]                 STARTUP_RATIO_SELECT,
   input  wire logic [1:0]                 BOOT_MODE_SELECT,
   // Power management control write port
   input  wire logic                       PMC_WR,
   input  wire logic [rcs_pkg::MULT_W-1:0] PMC_MULT,
   input  wire logic [rcs_pkg::DIV_W-1:0]  PMC_DIV,
   input  wire logic                       PMC_BYPASS,
   output logic                            PMC_TAKEN,
   // Core clock setting
   output logic [rcs_pkg::MULT_W-1:0]      CORE_CLK_MULT,
   output logic [rcs_pkg::DIV_W-1:0]       CORE_CLK_DIV,
   output logic                            CORE_CLK_DIRECT,
   output logic                            RATIO_RESERVED,
   // Core start
   output logic                            CORE_RESET_N,
   output logic                            CORE_RESET_OUT_N,
   output logic                            FETCH_VALID,
   output logic [rcs_pkg::ADDR_W-1:0]      FETCH_ADDR,
   output logic [1:0]                      BOOT_MODE,
   output logic                            PLL_LOCKED,
   // Core strobe requests
   input  wire logic                       CORE_RD_N,
   input  wire logic                       CORE_WR_N,
   input  wire logic                       CORE_ALE,
   // External strobe pins
   output logic                            RD_N_O,
   output logic                            RD_N_OE_N,
   output logic                            WR_N_O,
   output logic                            WR_N_OE_N,
   output logic                            ALE_O,
   output logic                            ALE_OE_N
);

   localparam logic [rcs_pkg::CNT_W-1:0] LOCK_LAST =
      rcs_pkg::CNT_W'(LOCK_CYCLES - 1);

   rcs_pkg::rcs_state_e state_ff;
   rcs_pkg::rcs_state_e nxt_state;
   logic [rcs_pkg::CNT_W-1:0] lock_cnt_ff;
   logic                      core_rst_n_ff;
   logic                      fetch_ff;
   logic [1:0]                boot_ff;
   logic [1:0]                ratio_ff;
   logic                      rd_n_ff;
   logic                      wr_n_ff;
   logic                      ale_ff;
   logic                      lock_done;

   rcs_clk_if cif ();

   // -----------------------------------------------------------------
   // Sequencer
   // -----------------------------------------------------------------
   assign lock_done = (lock_cnt_ff == LOCK_LAST);

   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         rcs_pkg::ST_RESET: nxt_state = rcs_pkg::ST_LOCK;
         rcs_pkg::ST_LOCK:  if (lock_done) nxt_state = rcs_pkg::ST_RUN;
         rcs_pkg::ST_RUN:   nxt_state = rcs_pkg::ST_RUN;
         default:           nxt_state = rcs_pkg::ST_RESET;
      endcase
   end

   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         state_ff <= rcs_pkg::ST_RESET;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // -----------------------------------------------------------------
   // Lock wait counter
   // -----------------------------------------------------------------
   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         lock_cnt_ff <= '0;
      end else if (state_ff == rcs_pkg::ST_LOCK && !lock_done) begin
         lock_cnt_ff <= lock_cnt_ff + 1'b1;
      end
   end

   // -----------------------------------------------------------------
   // Core reset and first fetch
   // -----------------------------------------------------------------
   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         core_rst_n_ff <= 1'b0;
      end else begin
         core_rst_n_ff <= (nxt_state == rcs_pkg::ST_RUN);
      end
   end

   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         fetch_ff <= 1'b0;
      end else begin
         fetch_ff <= (state_ff == rcs_pkg::ST_LOCK) && lock_done;
      end
   end

   // -----------------------------------------------------------------
   // Pin capture just after reset release
   // -----------------------------------------------------------------
   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         boot_ff  <= rcs_pkg::BOOT_RST;
         ratio_ff <= rcs_pkg::RATIO_6;
      end else if (state_ff == rcs_pkg::ST_RESET) begin
         boot_ff  <= BOOT_MODE_SELECT;
         ratio_ff <= STARTUP_RATIO_SELECT;
      end
   end

   assign cif.startup_load  = (state_ff == rcs_pkg::ST_RESET);
   assign cif.startup_code  = STARTUP_RATIO_SELECT;
   assign cif.core_in_reset = !core_rst_n_ff;
   assign cif.pmc_wr        = PMC_WR;
   assign cif.pmc_mult      = PMC_MULT;
   assign cif.pmc_div       = PMC_DIV;
   assign cif.pmc_bypass    = PMC_BYPASS;

   rcs_clkgen u_clkgen (
      .CLOCK (CLOCK),
      .RSTN  (RSTN),
      .cif   (cif)
   );

   // -----------------------------------------------------------------
   // External strobes
   // -----------------------------------------------------------------
   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         rd_n_ff <= 1'b1;
         wr_n_ff <= 1'b1;
         ale_ff  <= 1'b0;
      end else begin
         rd_n_ff <= CORE_RD_N | ~core_rst_n_ff;
         wr_n_ff <= CORE_WR_N | ~core_rst_n_ff;
         ale_ff  <= CORE_ALE & core_rst_n_ff;
      end
   end

   assign RD_N_O    = rd_n_ff;
   assign WR_N_O    = wr_n_ff;
   assign ALE_O     = ale_ff;
   assign RD_N_OE_N = ~RSTN;
   assign WR_N_OE_N = ~RSTN;
   assign ALE_OE_N  = ~RSTN;

   // -----------------------------------------------------------------
   // Outputs
   // -----------------------------------------------------------------
   assign CORE_RESET_N     = core_rst_n_ff;
   assign CORE_RESET_OUT_N = core_rst_n_ff;
   assign FETCH_VALID      = fetch_ff;
   assign FETCH_ADDR       = RESET_VECTOR;
   assign BOOT_MODE        = boot_ff;
   assign PLL_LOCKED       = core_rst_n_ff;
   assign RATIO_RESERVED   = rcs_pkg::ratio_direct(ratio_ff);
   assign CORE_CLK_MULT    = cif.mult;
   assign CORE_CLK_DIV     = cif.div;
   assign CORE_CLK_DIRECT  = cif.bypass;
   assign PMC_TAKEN        = cif.pmc_taken;

endmodule

// ---- verilog/rcs_pkg.sv ----
// Constants and decode helpers for the reset and clock start-up block
package rcs_pkg;

   // -----------------------------------------------------------------
   // Widths
   // -----------------------------------------------------------------
   localparam int unsigned MULT_W  = 7;
   localparam int unsigned DIV_W   = 3;
   localparam int unsigned CNT_W   = 13;
   localparam int unsigned ADDR_W  = 32;

   // -----------------------------------------------------------------
   // Start-up ratio codes and multipliers
   // -----------------------------------------------------------------
   localparam logic [1:0]        RATIO_6     = 2'h0;
   localparam logic [1:0]        RATIO_32    = 2'h1;
   localparam logic [1:0]        RATIO_16    = 2'h2;
   localparam logic [1:0]        RATIO_RSVD  = 2'h3;
   localparam logic [MULT_W-1:0] MULT_6      = 7'h06;
   localparam logic [MULT_W-1:0] MULT_32     = 7'h20;
   localparam logic [MULT_W-1:0] MULT_16     = 7'h10;
   localparam logic [MULT_W-1:0] MULT_DIRECT = 7'h01;

   // -----------------------------------------------------------------
   // Reset values
   // -----------------------------------------------------------------
   localparam logic [MULT_W-1:0] MULT_RST    = 7'h01;
   localparam logic [DIV_W-1:0]  DIV_RST     = 3'h1;
   localparam logic              BYPASS_RST  = 1'b1;
   localparam logic [1:0]        BOOT_RST    = 2'h0;

   // -----------------------------------------------------------------
   // Timing
   // -----------------------------------------------------------------
   localparam int unsigned LOCK_WAIT_INPUT_CLOCK_PIN = 4096;
   localparam int unsigned LOCK_CYCLES     = LOCK_WAIT_INPUT_CLOCK_PIN;
   localparam logic [ADDR_W-1:0] RESET_VECTOR = 32'h0009_0000;

   // -----------------------------------------------------------------
   // Start-up sequencer states
   // -----------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_RESET = 3'b001,
      ST_LOCK  = 3'b010,
      ST_RUN   = 3'b100
   } rcs_state_e;

   function automatic logic [MULT_W-1:0] ratio_mult(input logic [1:0] code);
      case (code)
         RATIO_6:  ratio_mult = MULT_6;
         RATIO_32: ratio_mult = MULT_32;
         RATIO_16: ratio_mult = MULT_16;
         default:  ratio_mult = MULT_DIRECT;
      endcase
   endfunction

   function automatic logic ratio_direct(input logic [1:0] code);
      ratio_direct = (code == RATIO_RSVD);
   endfunction

endpackage

// ---- verilog/rcs_clk_if.sv ----
// Carrier between the start-up sequencer and the core clock setting
interface rcs_clk_if;
   logic                       startup_load;
   logic [1:0]                 startup_code;
   logic                       core_in_reset;
   logic                       pmc_wr;
   logic [rcs_pkg::MULT_W-1:0] pmc_mult;
   logic [rcs_pkg::DIV_W-1:0]  pmc_div;
   logic                       pmc_bypass;
   logic                       pmc_taken;
   logic [rcs_pkg::MULT_W-1:0] mult;
   logic [rcs_pkg::DIV_W-1:0]  div;
   logic                       bypass;

   modport ctrl (output startup_load, startup_code, core_in_reset,
                 output pmc_wr, pmc_mult, pmc_div, pmc_bypass,
                 input  pmc_taken, mult, div, bypass);
   modport gen  (input  startup_load, startup_code, core_in_reset,
                 input  pmc_wr, pmc_mult, pmc_div, pmc_bypass,
                 output pmc_taken, mult, div, bypass);
endinterface

// ---- verilog/rcs_clkgen.sv ----
// Core clock ratio and source selection
module rcs_clkgen (
   // Clock and reset
   input  wire logic CLOCK,
   input  wire logic RSTN,
   // Sequencer side
   rcs_clk_if.gen    cif
);

   logic [rcs_pkg::MULT_W-1:0] mult_ff;
   logic [rcs_pkg::DIV_W-1:0]  div_ff;
   logic                       bypass_ff;
   logic                       taken_ff;
   logic                       pmc_ok;

   assign pmc_ok = cif.pmc_wr && !cif.core_in_reset;

   // -----------------------------------------------------------------
   // Ratio and source
   // -----------------------------------------------------------------
   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         mult_ff   <= rcs_pkg::MULT_RST;
         div_ff    <= rcs_pkg::DIV_RST;
         bypass_ff <= rcs_pkg::BYPASS_RST;
      end else if (cif.startup_load) begin
         mult_ff   <= rcs_pkg::ratio_mult(cif.startup_code);
         div_ff    <= rcs_pkg::DIV_RST;
         bypass_ff <= rcs_pkg::ratio_direct(cif.startup_code);
      end else if (pmc_ok) begin
         mult_ff   <= cif.pmc_mult;
         div_ff    <= cif.pmc_div;
         bypass_ff <= cif.pmc_bypass;
      end
   end

   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         taken_ff <= 1'b0;
      end else begin
         taken_ff <= pmc_ok;
      end
   end

   assign cif.mult      = mult_ff;
   assign cif.div       = div_ff;
   assign cif.bypass    = bypass_ff;
   assign cif.pmc_taken = taken_ff;

endmodule

// ---- bench/rcs_startup_sva.sv ----
// Concurrent checks on the start-up block's ports
module rcs_startup_sva #(
   parameter int unsigned LOCK_CYCLES = 8
) (
   // Clock, reset and pins
   input wire logic                       CLOCK,
   input wire logic                       RSTN,
   input wire logic [1:0]                 STARTUP_RATIO_SELECT,
   // Write port
   input wire logic                       PMC_WR,
   input wire logic                       PMC_TAKEN,
   // Core start and clock
   input wire logic [rcs_pkg::MULT_W-1:0] CORE_CLK_MULT,
   input wire logic                       CORE_CLK_DIRECT,
   input wire logic                       CORE_RESET_N,
   input wire logic                       CORE_RESET_OUT_N,
   input wire logic                       FETCH_VALID,
   input wire logic                       PLL_LOCKED,
   // Strobe enables
   input wire logic                       RD_N_OE_N,
   input wire logic                       WR_N_OE_N,
   input wire logic                       ALE_OE_N
);
   // ---------------------------------------------------------------
   // Lock wait counter and checks
   // ---------------------------------------------------------------
   localparam logic [6:0] MULTS [4] = '{7'h06, 7'h20, 7'h10, 7'h01};
   logic [15:0] wait_ff;
   default clocking @(posedge CLOCK); endclocking
   default disable iff (!RSTN);
   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) wait_ff <= 16'h0000;
      else if (!CORE_RESET_N) wait_ff <= wait_ff + 16'h0001;
   end
   a_reset_echo: assert property (CORE_RESET_OUT_N == CORE_RESET_N)
      else $error("Reset echo differs");
   a_strobe_float: assert property (disable iff (1'b0)
      {RD_N_OE_N, WR_N_OE_N, ALE_OE_N} == {3{!RSTN}}) else $error("Strobe enable wrong");
   a_lock_count: assert property ($rose(CORE_RESET_N) |-> wait_ff == LOCK_CYCLES + 1)
      else $error("Lock wait length wrong");
   a_fetch_pulse: assert property (FETCH_VALID == $rose(CORE_RESET_N))
      else $error("Fetch start out of place");
   a_pll_lock: assert property (PLL_LOCKED == CORE_RESET_N)
      else $error("Lock flag and core reset differ");
   a_ratio_mult: assert property ($rose(RSTN) |=>
      CORE_CLK_MULT == MULTS[$past(STARTUP_RATIO_SELECT)]) else $error("Start ratio wrong");
   a_ratio_direct: assert property ($rose(RSTN) |=>
      CORE_CLK_DIRECT == ($past(STARTUP_RATIO_SELECT) == 2'h3)) else $error("Source wrong");
   a_pmc_taken: assert property (PMC_TAKEN == $past(PMC_WR && CORE_RESET_N))
      else $error("Write acceptance wrong");
   c_core_run: cover property ($rose(CORE_RESET_N));
   c_pmc_write: cover property (PMC_TAKEN);
   c_direct_start: cover property ($rose(RSTN) ##1 CORE_CLK_DIRECT);
endmodule

bind rcs_startup rcs_startup_sva #(.LOCK_CYCLES(LOCK_CYCLES)) i_rcs_startup_sva (.*);

// ---- bench/rcs_board.sv ----
// Board model: reset generator and configuration straps
module rcs_board (
   // Clock and bench requests
   input  wire logic       clock,
   input  wire logic       rst_req,
   input  wire logic [1:0] ratio_in,
   input  wire logic [1:0] boot_in,
   // Pins toward the block
   output logic            rstn,
   output logic [1:0]      ratio_pins,
   output logic [1:0]      boot_pins
);
   // ---------------------------------------------------------------
   // Straps settle before reset goes low, reset low two cycles
   // ---------------------------------------------------------------
   logic [1:0] hold_ff = 2'h3;
   initial rstn = 1'b0;
   initial ratio_pins = 2'h0;
   initial boot_pins = 2'h0;
   always @(posedge clock) begin
      if (rst_req) begin
         ratio_pins <= ratio_in;
         boot_pins <= boot_in;
         hold_ff <= 2'h3;
      end else if (hold_ff != 2'h0) begin
         hold_ff <= hold_ff - 2'h1;
      end
      if (hold_ff == 2'h3) rstn <= 1'b0;
      if (hold_ff == 2'h1) rstn <= 1'b1;
   end
endmodule

// ---- bench/rcs_startup_tb.sv ----
// Self-checking testbench for the reset and clock start-up block
module rcs_startup_tb;
   timeunit 1ns;
   timeprecision 1ps;
   // ---------------------------------------------------------------
   // Signals, board model and block
   // ---------------------------------------------------------------
   localparam int L = 8;
   localparam logic [6:0] MULTS [4] = '{7'h06, 7'h20, 7'h10, 7'h01};
   int          failures = 0;
   int          check_count = 0;
   logic        clock = 1'b0;
   logic        rst_req = 1'b0;
   logic        wr = 1'b0;
   logic        pb = 1'b0;
   logic [1:0]  code_in = 2'h0;
   logic [1:0]  boot_in = 2'h0;
   logic [6:0]  pm = 7'h7f;
   logic [2:0]  pd = 3'h0;
   logic        rstn, taken, direct, core_rst, rst_out, fvalid, locked;
   logic        crd = 1'b1;
   logic        rres, rd_o, wr_o, ale_o;
   logic [1:0]  ratio, boot, bmode;
   logic [6:0]  mult;
   logic [2:0]  div;
   logic [31:0] faddr;
   wire  [2:0]  oe;
   rcs_board i_rcs_board (.clock(clock), .rst_req(rst_req), .ratio_in(code_in),
      .boot_in(boot_in), .rstn(rstn), .ratio_pins(ratio), .boot_pins(boot));
   rcs_startup #(.LOCK_CYCLES(L)) i_rcs_startup (.CLOCK(clock), .RSTN(rstn),
      .STARTUP_RATIO_SELECT(ratio), .BOOT_MODE_SELECT(boot), .PMC_WR(wr), .PMC_MULT(pm),
      .PMC_DIV(pd), .PMC_BYPASS(pb), .PMC_TAKEN(taken), .CORE_CLK_MULT(mult),
      .CORE_CLK_DIV(div), .CORE_CLK_DIRECT(direct), .RATIO_RESERVED(rres),
      .CORE_RESET_N(core_rst), .CORE_RESET_OUT_N(rst_out), .FETCH_VALID(fvalid),
      .FETCH_ADDR(faddr), .BOOT_MODE(bmode), .PLL_LOCKED(locked), .CORE_RD_N(crd),
      .CORE_WR_N(1'b1), .CORE_ALE(1'b0), .RD_N_O(rd_o), .RD_N_OE_N(oe[2]), .WR_N_O(wr_o),
      .WR_N_OE_N(oe[1]), .ALE_O(ale_o), .ALE_OE_N(oe[0]));
   always #10 clock = ~clock;

   task automatic chk(input logic [39:0] got, input logic [39:0] exp);
      check_count++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH time=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Board reset, a refused write in the first cycle after reset release, then run
   task automatic t_start(input logic [1:0] code, input logic [1:0] bm);
      int n;
      @(posedge clock);
      code_in <= code;
      boot_in <= bm;
      rst_req <= 1'b1;
      @(posedge clock);
      rst_req <= 1'b0;
      @(posedge clock);
      #1 chk({oe, rst_out, fvalid}, 5'h1c);
      @(posedge rstn);
      wr <= 1'b1;
      @(posedge clock);
      wr <= 1'b0;
      @(posedge clock);
      #1 chk(taken, 1'b0);
      for (n = 2; n < 100 && core_rst !== 1'b1; n++) begin
         @(posedge clock);
         #1;
      end
      chk(n, L + 1);
      chk({fvalid, rst_out, locked, faddr}, {3'h7, rcs_pkg::RESET_VECTOR});
      chk({mult, direct, oe, bmode}, {MULTS[code], code == 2'h3, 3'h0, bm});
      chk({div, rres, rd_o, wr_o, ale_o}, {3'h1, code == 2'h3, 3'b110});
      @(posedge clock);
      #1 chk(fvalid, 1'b0);
      $display("t_start done code=%h", code);
   endtask

   // Two back-to-back writes to the power management control port
   task automatic t_pmc;
      @(posedge clock);
      wr <= 1'b1;
      pm <= 7'h2a;
      pd <= 3'h5;
      pb <= 1'b0;
      crd <= 1'b0;
      @(posedge clock);
      pm <= 7'h13;
      pd <= 3'h2;
      pb <= 1'b1;
      crd <= 1'b1;
      #1 chk({taken, mult, div, direct, rd_o}, {1'b1, 7'h2a, 3'h5, 2'b00});
      @(posedge clock);
      wr <= 1'b0;
      #1 chk({taken, mult, div, direct, rd_o}, {1'b1, 7'h13, 3'h2, 2'b11});
      @(posedge clock);
      #1 chk({taken, mult}, {1'b0, 7'h13});
      $display("t_pmc done");
   endtask

   task automatic finish_test;
      $display("checks=%0d failures=%0d", check_count, failures);
      if (failures == 0 && check_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // Power-up lock is cut short by the first board reset
   initial begin
      @(posedge rstn);
      repeat (4) @(posedge clock);
      for (int i = 0; i < 4; i++) begin
         t_start(i[1:0], ~i[1:0]);
         t_pmc;
      end
      finish_test;
   end
   initial begin
      #50us;
      failures++;
      finish_test;
   end
endmodule
